// file: rtl/phy_link_power_ctrl.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "phy_ctl_defs.svh"

// Contract
// - crossover force field selects MDI, MDI-X, or automatic
// - downshift gigabit advertisement after configured failed attempts
// - leave downshift when gigabit partner appears
// - wake event sets pending when masked in
// - searching sends special bursts, status 00
// - looped back pulses give status 01
// - timeout gives 10, then normal autonegotiation
// - link loss re-enables detection, stops autonegotiation
// - power management enable bit, writable anytime
// - alternate low and wake until energy
// - normal link loss returns low after timeout
// - reset starts power management in low
// - forced speed: after energy stay normal
// - autonegotiation off in normal: stay normal
// - low sleeps programmed time with random offset
// - wake sends up to three bursts, alternating
// - link timeout built from high and low fields
// - energy in low moves to normal
module phy_link_power_ctrl
   import phy_ctl_pkg::*;
#(
   parameter int MS_CYCLES = `CLK_HZ / `MS_PER_S
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // line side status
   input  wire logic        energy_detect,
   input  wire logic        link_up,
   input  wire logic        gig_attempt_fail,
   input  wire logic        partner_gig_seen,
   input  wire logic        flp_loopback_seen,
   input  wire logic        wake_event,
   // line side control
   output logic             mdi_forced,
   output logic             mdi_crossed,
   output logic             auto_mdix_run,
   output logic             pair_swap_en,
   output logic             adv_gig,
   output logic             tx_burst,
   output logic             burst_pair_b,
   output logic             low_power,
   output logic             an_run,
   output logic             pd_flp,
   output logic             ten_te,
   output logic             wake_out
);
   import phy_ctl_pkg::*;

   state_t s_q;
   state_t s_d;

   logic        wr;
   logic        rd;
   logic [7:0]  rnd;
   logic [15:0] sleep_ms;
   logic [15:0] wake_ms;
   logic [15:0] link_ms;
   logic [1:0]  pd_code;
   logic [31:0] ctrl_rd;
   logic [31:0] tmr_rd;
   logic [31:0] st_rd;

   always_comb begin
      rnd = (s_q.lfsr > 8'd140) ? s_q.lfsr - 8'd141 : s_q.lfsr;
      // random term spans the negative and positive spread
      sleep_ms = 16'({14'd0, s_q.sleep_sel} + 16'd1) * 16'(`SLEEP_STEP_MS)
               - 16'(`SLEEP_NEG_MS) + {8'h00, rnd};
      unique case (s_q.wake_sel)
         2'h0: wake_ms = 16'(`WAKE0_MS);
         2'h1: wake_ms = 16'(`WAKE1_MS);
         2'h2: wake_ms = 16'(`WAKE2_MS);
         2'h3: wake_ms = 16'(`WAKE3_MS);
      endcase
      link_ms = 16'({12'h000, s_q.lt_hi, s_q.lt_lo} + 16'd1) * 16'(`LINK_STEP_MS);
      unique case (s_q.pd)
         PD_FOUND: pd_code = 2'h1;
         PD_DONE:  pd_code = 2'h2;
         default:  pd_code = 2'h0;
      endcase
      ctrl_rd = 32'h0000_0000;
      ctrl_rd[`CTRL_AN_EN]                    = s_q.an_en;
      ctrl_rd[`CTRL_PWR_DOWN]                 = s_q.pwr_down;
      ctrl_rd[`CTRL_PD_EN]                    = s_q.pd_en;
      ctrl_rd[`CTRL_PM_EN]                    = s_q.pm_en;
      ctrl_rd[`CTRL_DS_EN]                    = s_q.ds_en;
      ctrl_rd[`CTRL_DS_CFG+1:`CTRL_DS_CFG]    = s_q.ds_cfg;
      ctrl_rd[`CTRL_XOVER_SEL+1:`CTRL_XOVER_SEL] = s_q.xover_sel;
      ctrl_rd[`CTRL_XOVER_DIS]                = s_q.xover_dis;
      ctrl_rd[`CTRL_SWAP_DIS]                 = s_q.swap_dis;
      ctrl_rd[`CTRL_LPI_RX_DIS]               = s_q.lpi_rx_dis;
      ctrl_rd[`CTRL_WAKE_MASK]                = s_q.wake_mask;
      tmr_rd = 32'h0000_0000;
      tmr_rd[`TMR_SLEEP_SEL+1:`TMR_SLEEP_SEL] = s_q.sleep_sel;
      tmr_rd[`TMR_WAKE_SEL+1:`TMR_WAKE_SEL]   = s_q.wake_sel;
      tmr_rd[`TMR_LINK_HI+1:`TMR_LINK_HI]     = s_q.lt_hi;
      tmr_rd[`TMR_LINK_LO+1:`TMR_LINK_LO]     = s_q.lt_lo;
      st_rd = 32'h0000_0000;
      st_rd[`ST_PD_STAT+1:`ST_PD_STAT]        = pd_code;
      st_rd[`ST_DS_ACTIVE]                    = s_q.ds_active;
      st_rd[`ST_LINK]                         = s_q.link_d;
      st_rd[`ST_PM_STATE+1:`ST_PM_STATE]      = s_q.pm;
      st_rd[`ST_ENERGY]                       = s_q.energy;
      st_rd[`ST_TEN_TE]                       = s_q.ten_te;
   end

   always_comb begin
      s_d = s_q;
      // one wait state: the answer comes in the second access cycle
      wr = psel & penable & s_q.pready & pwrite;
      rd = psel & penable & ~s_q.pready & ~pwrite;
      s_d.pready  = psel & penable & ~s_q.pready;
      s_d.pslverr = 1'b0;
      // read data only stands with pready, idle bus reads zero
      s_d.prdata  = 32'h0000_0000;
      if (psel && penable && !s_q.pready) begin
         unique case (paddr)
            `OFF_CTRL:   s_d.prdata = rd ? ctrl_rd : 32'h0000_0000;
            `OFF_TIMER:  s_d.prdata = rd ? tmr_rd : 32'h0000_0000;
            `OFF_STATUS: s_d.prdata = rd ? st_rd : 32'h0000_0000;
            `OFF_WAKE:   s_d.prdata = rd ? {31'h0, s_q.wake_pend} : 32'h0000_0000;
            default: begin
               s_d.prdata  = 32'h0000_0000;
               s_d.pslverr = 1'b1;
            end
         endcase
      end
      if (wr) begin
         unique case (paddr)
            `OFF_CTRL: begin
               s_d.an_en      = pwdata[`CTRL_AN_EN];
               s_d.pwr_down   = pwdata[`CTRL_PWR_DOWN];
               s_d.pd_en      = pwdata[`CTRL_PD_EN];
               s_d.pm_en      = pwdata[`CTRL_PM_EN];
               s_d.ds_en      = pwdata[`CTRL_DS_EN];
               s_d.ds_cfg     = pwdata[`CTRL_DS_CFG+1:`CTRL_DS_CFG];
               s_d.xover_sel  = pwdata[`CTRL_XOVER_SEL+1:`CTRL_XOVER_SEL];
               s_d.xover_dis  = pwdata[`CTRL_XOVER_DIS];
               s_d.swap_dis   = pwdata[`CTRL_SWAP_DIS];
               s_d.lpi_rx_dis = pwdata[`CTRL_LPI_RX_DIS];
               s_d.wake_mask  = pwdata[`CTRL_WAKE_MASK];
            end
            `OFF_TIMER: begin
               s_d.sleep_sel = pwdata[`TMR_SLEEP_SEL+1:`TMR_SLEEP_SEL];
               s_d.wake_sel  = pwdata[`TMR_WAKE_SEL+1:`TMR_WAKE_SEL];
               s_d.lt_hi     = pwdata[`TMR_LINK_HI+1:`TMR_LINK_HI];
               s_d.lt_lo     = pwdata[`TMR_LINK_LO+1:`TMR_LINK_LO];
            end
            `OFF_WAKE: if (pwdata[0]) s_d.wake_pend = 1'b0;
            default: ;
         endcase
      end
      // set after the clear so a coincident event survives
      if (wake_event && s_q.wake_mask) begin
         s_d.wake_pend = 1'b1;
      end

      s_d.energy = energy_detect;
      s_d.link_d = link_up;
      s_d.lfsr   = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};
      s_d.ms_tick = 1'b0;
      if (s_q.ms_cnt == 15'(MS_CYCLES - 1)) begin
         s_d.ms_cnt  = 15'h0000;
         s_d.ms_tick = 1'b1;
      end else begin
         s_d.ms_cnt = s_q.ms_cnt + 15'h0001;
      end

      // downshift: fail counter resets on link
      if (!s_q.ds_en) begin
         s_d.ds_active = 1'b0;
         s_d.fail_cnt  = 3'h0;
      end else if (s_q.ds_active && partner_gig_seen) begin
         s_d.ds_active = 1'b0;
         s_d.fail_cnt  = 3'h0;
      end else if (link_up) begin
         s_d.fail_cnt = 3'h0;
      end else if (gig_attempt_fail && !s_q.ds_active) begin
         if (s_q.fail_cnt + 3'h1 >= {1'b0, s_q.ds_cfg} + 3'(`DS_MIN_TRIES)) begin
            s_d.ds_active = 1'b1;
            s_d.fail_cnt  = 3'h0;
         end else begin
            s_d.fail_cnt = s_q.fail_cnt + 3'h1;
         end
      end

      // powered device detection
      if (!(s_q.pd_en && s_q.an_en)) begin
         s_d.pd = PD_IDLE;
      end else begin
         unique case (s_q.pd)
            PD_IDLE: begin
               s_d.pd     = PD_SEARCH;
               s_d.pd_tmr = 16'(`PD_TIMEOUT_MS);
            end
            PD_SEARCH: begin
               if (flp_loopback_seen) begin
                  s_d.pd = PD_FOUND;
               end else if (s_q.ms_tick) begin
                  if (s_q.pd_tmr == 16'h0000) s_d.pd = PD_DONE;
                  else s_d.pd_tmr = s_q.pd_tmr - 16'h0001;
               end
            end
            PD_FOUND, PD_DONE: begin
               if (s_q.link_d && !link_up) begin
                  s_d.pd     = PD_SEARCH;
                  s_d.pd_tmr = 16'(`PD_TIMEOUT_MS);
               end
            end
         endcase
      end
      s_d.pd_flp = (s_d.pd == PD_SEARCH);
      s_d.an_run = s_q.an_en && (s_d.pd != PD_SEARCH);

      // power management
      s_d.tx_burst = 1'b0;
      if (!s_q.pm_en) begin
         s_d.pm = PM_OFF;
      end else begin
         unique case (s_q.pm)
            PM_OFF: begin
               // enabled mid-operation: keep a live link
               s_d.pm  = PM_NORMAL;
               s_d.tmr = link_ms;
            end
            PM_LOW: begin
               if (s_q.energy) begin
                  s_d.pm  = PM_NORMAL;
                  s_d.tmr = link_ms;
               end else if (s_q.ms_tick) begin
                  if (s_q.tmr == 16'h0000) begin
                     s_d.pm     = PM_WAKE;
                     s_d.tmr    = wake_ms;
                     s_d.gap    = 5'h00;
                     s_d.bursts = 2'h0;
                  end else begin
                     s_d.tmr = s_q.tmr - 16'h0001;
                  end
               end
            end
            PM_WAKE: begin
               if (s_q.ms_tick) begin
                  if (s_q.tmr == 16'h0000) begin
                     s_d.pm  = PM_LOW;
                     s_d.tmr = sleep_ms;
                  end else begin
                     s_d.tmr = s_q.tmr - 16'h0001;
                     if (s_q.gap == 5'h00 && s_q.bursts != 2'(`FLP_BURSTS)) begin
                        s_d.tx_burst     = 1'b1;
                        s_d.burst_pair_b = s_q.bursts[0];
                        s_d.bursts       = s_q.bursts + 2'h1;
                        s_d.gap          = 5'(`FLP_GAP_MS - 1);
                     end else if (s_q.gap != 5'h00) begin
                        s_d.gap = s_q.gap - 5'h01;
                     end
                  end
               end
            end
            PM_NORMAL: begin
               // with autonegotiation off the state is held while an_en stays clear
               if (!s_q.an_en || link_up) begin
                  s_d.tmr = link_ms;
               end else if (s_q.ms_tick) begin
                  if (s_q.tmr == 16'h0000) begin
                     s_d.pm  = PM_LOW;
                     s_d.tmr = sleep_ms;
                  end else begin
                     s_d.tmr = s_q.tmr - 16'h0001;
                  end
               end
            end
         endcase
      end
      s_d.low_power = s_q.pwr_down || (s_d.pm == PM_LOW) || (s_d.pm == PM_WAKE);

      // pair assignment
      s_d.mdi_forced    = s_q.xover_sel[1];
      s_d.mdi_crossed   = (s_q.xover_sel == 2'h3);
      s_d.auto_mdix_run = !s_q.xover_sel[1] && (s_q.an_en || !s_q.xover_dis);
      s_d.pair_swap_en  = !s_q.xover_sel[1] && !s_q.swap_dis;
      s_d.adv_gig       = !s_d.ds_active;
      s_d.ten_te        = s_q.lpi_rx_dis;
      s_d.wake_out      = s_d.wake_pend;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.an_en         <= 1'b1;
         s_q.pm_en         <= 1'b1;
         s_q.sleep_sel     <= 2'h1;
         s_q.pm            <= PM_LOW;
         s_q.lfsr          <= 8'h5A;
         s_q.auto_mdix_run <= 1'b1;
         s_q.pair_swap_en  <= 1'b1;
         s_q.adv_gig       <= 1'b1;
         s_q.low_power     <= 1'b1;
         s_q.an_run        <= 1'b1;
         s_q.tmr           <= 16'h0000;
      end else begin
         s_q <= s_d;
      end
   end

   assign pready        = s_q.pready;
   assign pslverr       = s_q.pslverr;
   assign prdata        = s_q.prdata;
   assign mdi_forced    = s_q.mdi_forced;
   assign mdi_crossed   = s_q.mdi_crossed;
   assign auto_mdix_run = s_q.auto_mdix_run;
   assign pair_swap_en  = s_q.pair_swap_en;
   assign adv_gig       = s_q.adv_gig;
   assign tx_burst      = s_q.tx_burst;
   assign burst_pair_b  = s_q.burst_pair_b;
   assign low_power     = s_q.low_power;
   assign an_run        = s_q.an_run;
   assign pd_flp        = s_q.pd_flp;
   assign ten_te        = s_q.ten_te;
   assign wake_out      = s_q.wake_out;

endmodule

// file: rtl/phy_ctl_defs.svh
`ifndef PHY_CTL_DEFS_SVH
`define PHY_CTL_DEFS_SVH

// register byte offsets
`define OFF_CTRL        12'h000
`define OFF_TIMER       12'h004
`define OFF_STATUS      12'h008
`define OFF_WAKE        12'h00C

// control register fields
`define CTRL_AN_EN      0
`define CTRL_PWR_DOWN   1
`define CTRL_PD_EN      2
`define CTRL_PM_EN      3
`define CTRL_DS_EN      4
`define CTRL_DS_CFG     5
`define CTRL_XOVER_SEL  7
`define CTRL_XOVER_DIS  9
`define CTRL_SWAP_DIS   10
`define CTRL_LPI_RX_DIS 11
`define CTRL_WAKE_MASK  12
`define CTRL_RST        32'h0000_0009

// timer register fields
`define TMR_SLEEP_SEL   0
`define TMR_WAKE_SEL    2
`define TMR_LINK_HI     4
`define TMR_LINK_LO     6
`define TMR_RST         32'h0000_0001

// status register fields
`define ST_PD_STAT      0
`define ST_DS_ACTIVE    2
`define ST_LINK         3
`define ST_PM_STATE     4
`define ST_ENERGY       6
`define ST_TEN_TE       7

// timing
`define CLK_HZ          25000000
`define MS_PER_S        1000
`define SLEEP_STEP_MS   1000
`define SLEEP_NEG_MS    80
`define SLEEP_POS_MS    60
`define LINK_STEP_MS    1000
`define FLP_GAP_MS      16
`define FLP_BURSTS      3
`define WAKE0_MS        160
`define WAKE1_MS        400
`define WAKE2_MS        800
`define WAKE3_MS        2000
`define PD_TIMEOUT_MS   500
`define DS_MIN_TRIES    2

`endif

// file: rtl/phy_ctl_pkg.sv
package phy_ctl_pkg;

   typedef enum logic [1:0] {PM_OFF, PM_LOW, PM_WAKE, PM_NORMAL} pm_state_t;
   typedef enum logic [1:0] {PD_IDLE, PD_SEARCH, PD_FOUND, PD_DONE} pd_state_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        an_en;
      logic        pwr_down;
      logic        pd_en;
      logic        pm_en;
      logic        ds_en;
      logic [1:0]  ds_cfg;
      logic [1:0]  xover_sel;
      logic        xover_dis;
      logic        swap_dis;
      logic        lpi_rx_dis;
      logic        wake_mask;
      logic [1:0]  sleep_sel;
      logic [1:0]  wake_sel;
      logic [1:0]  lt_hi;
      logic [1:0]  lt_lo;
      logic        wake_pend;
      logic        ds_active;
      logic [2:0]  fail_cnt;
      pd_state_t   pd;
      pm_state_t   pm;
      logic        energy;
      logic        link_d;
      logic [14:0] ms_cnt;
      logic        ms_tick;
      logic [15:0] tmr;
      logic [15:0] pd_tmr;
      logic [4:0]  gap;
      logic [1:0]  bursts;
      logic [7:0]  lfsr;
      logic        mdi_forced;
      logic        mdi_crossed;
      logic        auto_mdix_run;
      logic        pair_swap_en;
      logic        adv_gig;
      logic        tx_burst;
      logic        burst_pair_b;
      logic        low_power;
      logic        an_run;
      logic        pd_flp;
      logic        ten_te;
      logic        wake_out;
   } state_t;

endpackage

// file: test/link_power_properties.sv
`timescale 1ns/1ns
module link_power_properties (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   // line
   input wire logic        partner_gig_seen,
   input wire logic        mdi_forced,
   input wire logic        mdi_crossed,
   input wire logic        auto_mdix_run,
   input wire logic        pair_swap_en,
   input wire logic        adv_gig,
   input wire logic        tx_burst,
   input wire logic        low_power,
   input wire logic        an_run,
   input wire logic        pd_flp
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_pulse;
      tx_burst ##1 !tx_burst;
   endsequence
   property p_cross;
      mdi_crossed |-> mdi_forced;
   endproperty
   property p_forced;
      mdi_forced |-> !auto_mdix_run && !pair_swap_en;
   endproperty
   property p_wait;
      psel && penable && !pready |=> pready;
   endproperty
   property p_one;
      pready |=> !pready;
   endproperty
   property p_err;
      pslverr |-> pready;
   endproperty
   property p_rdata;
      !pready |-> prdata == 32'h0;
   endproperty
   property p_burst;
      tx_burst |-> low_power and s_pulse;
   endproperty
   property p_gap;
      tx_burst |=> !tx_burst [*8];
   endproperty
   property p_regain;
      !adv_gig && partner_gig_seen |-> ##[1:2] adv_gig;
   endproperty
   property p_excl;
      pd_flp |-> !an_run;
   endproperty
   property p_rst;
      $rose(presetn) |-> low_power;
   endproperty
   a_cross: assert property (p_cross) else $error("crossed not forced");
   a_forced: assert property (p_forced) else $error("auto left on");
   a_wait: assert property (p_wait) else $error("no ready");
   a_one: assert property (p_one) else $error("ready too long");
   a_err: assert property (p_err) else $error("error alone");
   a_rdata: assert property (p_rdata) else $error("data idle");
   a_burst: assert property (p_burst) else $error("burst wrong");
   a_gap: assert property (p_gap) else $error("bursts close");
   a_regain: assert property (p_regain) else $error("gig not back");
   a_excl: assert property (p_excl) else $error("search with autoneg");
   a_rst: assert property (p_rst) else $error("not low after reset");
endmodule
bind phy_link_power_ctrl link_power_properties i_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .partner_gig_seen(partner_gig_seen), .mdi_forced(mdi_forced), .mdi_crossed(mdi_crossed),
   .auto_mdix_run(auto_mdix_run), .pair_swap_en(pair_swap_en), .adv_gig(adv_gig),
   .tx_burst(tx_burst), .low_power(low_power), .an_run(an_run), .pd_flp(pd_flp));

// file: test/link_partner_model.sv
`timescale 1ns/1ns
module link_partner_model (
   // clock, reset and scenario
   input wire logic pclk,
   input wire logic presetn,
   input wire logic present,
   input wire logic needs_power,
   input wire logic gig_capable,
   input wire logic wake_req,
   // from the block
   input wire logic pd_flp,
   input wire logic an_run,
   input wire logic adv_gig,
   // to the block
   output logic     energy_detect,
   output logic     link_up,
   output logic     gig_attempt_fail,
   output logic     partner_gig_seen,
   output logic     flp_loopback_seen,
   output logic     wake_event
);
   logic [3:0] try_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {energy_detect, link_up, gig_attempt_fail} <= 3'h0;
         {partner_gig_seen, flp_loopback_seen, wake_event} <= 3'h0;
         try_q <= 4'h0;
      end else begin
         try_q <= try_q + 4'h1;
         energy_detect <= present;
         // a gigabit advert fails on a partner without gigabit
         link_up <= present & (gig_capable | !adv_gig | !an_run);
         // unpowered device only loops pulses while cable has no live partner
         flp_loopback_seen <= needs_power & pd_flp & !present;
         gig_attempt_fail <= present & !gig_capable & adv_gig & an_run & (try_q == 4'h0);
         partner_gig_seen <= present & gig_capable & (try_q == 4'h0);
         wake_event <= wake_req;
      end
   end
endmodule

// file: test/copper_phy_link_power_ctrl_test.sv
`timescale 1ns/1ns
`include "phy_ctl_defs.svh"
module copper_phy_link_power_ctrl_test;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic        energy_detect, link_up, gig_attempt_fail, partner_gig_seen;
   logic        flp_loopback_seen, wake_event, mdi_forced, mdi_crossed;
   logic        auto_mdix_run, pair_swap_en, adv_gig, tx_burst, burst_pair_b;
   logic        low_power, an_run, pd_flp, ten_te, wake_out;
   logic        present, needs_power, gig_capable, wake_req;
   int          errors, cmp_count, n;

   phy_link_power_ctrl #(.MS_CYCLES(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .pslverr, .prdata, .energy_detect, .link_up,
      .gig_attempt_fail, .partner_gig_seen, .flp_loopback_seen, .wake_event, .mdi_forced,
      .mdi_crossed, .auto_mdix_run, .pair_swap_en, .adv_gig, .tx_burst, .burst_pair_b,
      .low_power, .an_run, .pd_flp, .ten_te, .wake_out);
   link_partner_model i_lp (.pclk, .presetn, .present, .needs_power, .gig_capable,
      .wake_req, .pd_flp, .an_run, .adv_gig, .energy_detect, .link_up, .gig_attempt_fail,
      .partner_gig_seen, .flp_loopback_seen, .wake_event);

   initial begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end

   task test_done;
      if (errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         errors++;
         test_done;
      end
   endtask

   function logic pick(input int s);
      case (s)
         0: pick = low_power;
         1: pick = tx_burst;
         2: pick = adv_gig;
         default: pick = pd_flp;
      endcase
   endfunction

   // counts edges until the chosen output reaches v; overrun ends the run
   task wait_on(input int s, input logic v, input int lim);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pick(s) !== v && n < lim);
      if (n >= lim) begin
         errors++;
         test_done;
      end
   endtask

   task pulse_wake;
      wake_req <= 1'b1;
      @(posedge pclk);
      wake_req <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata, present, needs_power, wake_req} = '0;
      gig_capable = 1'b1;
      errors = 0;
      cmp_count = 0;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFF_CTRL, 32'h0);
      check(rv, `CTRL_RST);
      apb(1'b0, `OFF_TIMER, 32'h0);
      check(rv, `TMR_RST);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rv[5:4] == 2'h0 || rv[5:4] == 2'h3, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      check({ev, rv[30:0]}, 32'h8000_0000);
      for (int i = 0; i < 32; i++) begin
         apb(1'b1, `OFF_CTRL, 32'h8 | i[4] | (i[1:0] << 7) | (i[2] << 9) | (i[3] << 10));
         repeat (2) @(posedge pclk);
         check({mdi_forced, mdi_crossed, auto_mdix_run, pair_swap_en},
               {i[1], i[1:0] == 2'h3, !i[1] & (i[4] | !i[2]), !i[1] & !i[3]});
      end
      apb(1'b1, `OFF_CTRL, 32'h1809);
      pulse_wake;
      check({ten_te, wake_out}, 32'h3);
      apb(1'b0, `OFF_WAKE, 32'h0);
      check(rv, 32'h1);
      apb(1'b1, `OFF_WAKE, 32'h1);
      apb(1'b1, `OFF_CTRL, 32'h9);
      pulse_wake;
      apb(1'b0, `OFF_WAKE, 32'h0);
      check(rv, 32'h0);
      apb(1'b1, `OFF_TIMER, 32'h40);
      // a long gap marks the first burst of a wake period
      do wait_on(1, 1'b1, 10000); while (n < 1000);
      check(burst_pair_b, 32'h0);
      wait_on(1, 1'b1, 100);
      check({burst_pair_b, n >= 60 && n <= 68}, 32'h3);
      wait_on(1, 1'b1, 100);
      check(burst_pair_b, 32'h0);
      wait_on(1, 1'b1, 6000);
      check(n >= 3600 && n <= 5000, 32'h1);
      present <= 1'b1;
      wait_on(0, 1'b0, 1000);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rv[5:4], 32'h3);
      gig_capable <= 1'b0;
      apb(1'b1, `OFF_CTRL, 32'h19);
      wait_on(2, 1'b0, 200);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rv[2], 32'h1);
      gig_capable <= 1'b1;
      wait_on(2, 1'b1, 100);
      present <= 1'b0;
      wait_on(0, 1'b1, 9000);
      check(n >= 7990 && n <= 8100, 32'h1);
      present <= 1'b1;
      wait_on(0, 1'b0, 1000);
      apb(1'b1, `OFF_CTRL, 32'h8);
      present <= 1'b0;
      repeat (9000) @(posedge pclk);
      check(low_power, 32'h0);
      apb(1'b1, `OFF_CTRL, 32'h5);
      wait_on(3, 1'b1, 100);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rv[1:0], 32'h0);
      wait_on(3, 1'b0, 2200);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check({rv[1:0], an_run}, 32'h5);
      present <= 1'b1;
      repeat (5) @(posedge pclk);
      present <= 1'b0;
      wait_on(3, 1'b1, 50);
      needs_power <= 1'b1;
      repeat (10) @(posedge pclk);
      apb(1'b0, `OFF_STATUS, 32'h0);
      check(rv[1:0], 32'h1);
      test_done;
   end
endmodule
